// ===== hdl/formatter_pkg.sv
// formatter_pkg: constants shared by the pixel component formatter.
// assumes one 100 MHz clock domain and a plain register port.
package formatter_pkg;

  // clock rate, kept for reference by users of the block
  localparam int unsigned CLK_PERIOD_NS = 10;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] FMT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] EXT_CSR_OFS    = 8'h04;
  localparam logic [7:0] TEST_CSR_OFS   = 8'h08;
  localparam logic [7:0] STAMP_CSR_OFS  = 8'h0c;
  localparam logic [7:0] CRC_CSR_OFS    = 8'h10;
  localparam logic [7:0] STATUS_OFS     = 8'h14;
  localparam logic [7:0] LAST_CRC_OFS   = 8'h18;
  localparam logic [7:0] LAST_STAMP_OFS = 8'h1c;

  // field positions
  localparam int unsigned WIDE_BIT     = 0;  // format ctrl: 16-bit mode
  localparam int unsigned VFMT_LSB     = 4;  // format ctrl: video format
  localparam int unsigned ENABLE_BIT   = 0;  // every feature csr
  localparam int unsigned PATTERN_BIT  = 1;  // test csr: 0 ramp, 1 white

  // values
  localparam logic [2:0]  VFMT_SCALABLE = 3'h7;
  localparam logic [2:0]  VFMT_RESET    = 3'h0;
  localparam logic [7:0]  CHROMA_ZERO   = 8'h80;
  localparam logic [11:0] WHITE_LEVEL   = 12'hfff;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam logic [31:0] CRC_POLY_REV  = 32'hedb88320;

  // trailer record: identifier bytes then payload bytes, low byte first
  localparam logic [5:0] GUID_BYTES  = 6'h10;
  localparam logic [5:0] REC_LAST    = 6'h13;

  // feature identifiers; values are arbitrary
  localparam logic [127:0] GUID_STAMP = 128'h0123456789abcdef0011223344556677;
  localparam logic [127:0] GUID_CRC   = 128'h89abcdef0123456776655443322110ff;

  typedef enum logic [0:0] {
    S_PIX = 1'b0,
    S_TRL = 1'b1
  } fmt_state_e;

endpackage : formatter_pkg

// ===== hdl/pixel_component_formatter.sv
// pixel_component_formatter: turns captured components into output bytes
// and appends per-image trailer records (time stamp, checksum).
// assumes sensor, time base and register port all run on clock.
//
// Summary of operation
// - 8-bit mono/raw: byte value equals signal level 0..255.
// - chroma: offset binary, 0x80 is zero, 0xff +127, 0x00 -128.
// - 16-bit mode: unsigned word, low byte sent before high byte.
// - 16-bit mode: 12 signal bits, largest word 0x0fff (4095).
// - test image enabled: generated pattern replaces captured data.
// - time stamp enabled: bus cycle time taken at exposure start.
// - checksum enabled: crc computed over every transmitted image.
// - stamp and checksum trail the pixel data of their image.
// - each appended record carries its feature's 128-bit identifier.
// - one control register per feature holds enable and parameters.
// - extended stream disabled: no appended results at all.
// - records appended only in scalable format 7.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module pixel_component_formatter (
  input  wire logic        clock,
  input  wire logic        reset_n,
  // captured components; chroma level is two's complement in [11:4]
  input  wire logic        in_valid,
  input  wire logic [11:0] in_level,
  input  wire logic        in_chroma,
  input  wire logic        in_first,
  input  wire logic        in_last,
  output logic             in_ready,
  // time base
  input  wire logic        exposure_start,
  input  wire logic [31:0] cycle_time,
  // byte stream toward the host link
  output logic             out_valid,
  output logic [7:0]       out_data,
  output logic             out_last,
  input  wire logic        out_ready,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);
  import formatter_pkg::*;

  fmt_state_e  state_r;
  logic        wide_r;
  logic [2:0]  vfmt_r;
  logic        ext_en_r;
  logic        test_en_r;
  logic        test_white_r;
  logic        stamp_en_r;
  logic        crc_en_r;
  logic        in_ready_r;
  logic        out_valid_r;
  logic [7:0]  out_data_r;
  logic        out_last_r;
  logic [31:0] rdata_r;
  logic        hi_pend_r;
  logic [7:0]  hi_byte_r;
  logic        hi_last_r;
  logic        frm_test_r;
  logic        frm_stamp_r;
  logic        frm_crc_r;
  logic [11:0] pattern_r;
  logic [31:0] stamp_cap_r;
  logic [31:0] frm_time_r;
  logic [31:0] crc_r;
  logic [5:0]  trl_idx_r;
  logic        rec_r;
  logic [31:0] last_crc_r;
  logic [31:0] last_stamp_r;
  logic [15:0] frames_r;
  logic        slot_free;
  logic        fire;
  logic        hi_load;
  logic        trl_load;
  logic        trl_done;
  logic        live_app;
  logic        f_test;
  logic        f_stamp;
  logic        f_crc;
  logic        f_app;
  logic [11:0] pat_cur;
  logic [11:0] level;
  logic [7:0]  lo_byte;
  logic [7:0]  trl_byte;
  logic [127:0] guid_cur;
  logic [31:0] payload;
  // crc-32, reflected, one byte per call
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY_REV) : (x >> 1);
    end
    return x;
  endfunction : crc_byte
  // handshake terms; in_ready only rises when the slot is known empty
  assign slot_free = !out_valid_r || out_ready;
  assign fire      = in_valid && in_ready_r;
  assign hi_load   = (state_r == S_PIX) && hi_pend_r && slot_free;
  assign trl_load  = (state_r == S_TRL) && slot_free;
  assign trl_done  = (trl_idx_r == REC_LAST) && (rec_r || !frm_crc_r);
  // feature set is frozen at an image's first component
  assign live_app = ext_en_r && (vfmt_r == VFMT_SCALABLE);
  assign f_test   = in_first ? test_en_r : frm_test_r;
  assign f_stamp  = in_first ? (live_app && stamp_en_r) : frm_stamp_r;
  assign f_crc    = in_first ? (live_app && crc_en_r) : frm_crc_r;
  assign f_app    = f_stamp || f_crc;
  // ramp restarts on every image so each test frame is identical
  assign pat_cur = test_white_r ? WHITE_LEVEL
                 : (in_first ? 12'h000 : pattern_r);
  assign level   = f_test ? pat_cur : in_level;
  // component byte mapping for the low (or only) byte
  assign lo_byte = wide_r    ? level[7:0]
                 : in_chroma ? {~level[11], level[10:4]}
                 : level[11:4];

  // trailer byte: identifier first, then payload, both low byte first
  assign guid_cur = rec_r ? GUID_CRC : GUID_STAMP;
  assign payload  = rec_r ? ~crc_r : frm_time_r;
  assign trl_byte = (trl_idx_r < GUID_BYTES)
                  ? guid_cur[{trl_idx_r[3:0], 3'b000} +: 8]
                  : payload[{trl_idx_r[1:0], 3'b000} +: 8];

  // register writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wide_r       <= 1'b0;
      vfmt_r       <= VFMT_RESET;
      ext_en_r     <= 1'b0;
      test_en_r    <= 1'b0;
      test_white_r <= 1'b0;
      stamp_en_r   <= 1'b0;
      crc_en_r     <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        FMT_CTRL_OFS: begin
          wide_r <= reg_wdata[WIDE_BIT];
          vfmt_r <= reg_wdata[VFMT_LSB +: 3];
        end
        EXT_CSR_OFS:   ext_en_r   <= reg_wdata[ENABLE_BIT];
        TEST_CSR_OFS: begin
          test_en_r    <= reg_wdata[ENABLE_BIT];
          test_white_r <= reg_wdata[PATTERN_BIT];
        end
        STAMP_CSR_OFS: stamp_en_r <= reg_wdata[ENABLE_BIT];
        CRC_CSR_OFS:   crc_en_r   <= reg_wdata[ENABLE_BIT];
        default: ;
      endcase
    end
  end

  // register reads, answered one cycle later; unmapped reads give zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        FMT_CTRL_OFS:   rdata_r <= {25'h0, vfmt_r, 3'h0, wide_r};
        EXT_CSR_OFS:    rdata_r <= {31'h0, ext_en_r};
        TEST_CSR_OFS:   rdata_r <= {30'h0, test_white_r, test_en_r};
        STAMP_CSR_OFS:  rdata_r <= {31'h0, stamp_en_r};
        CRC_CSR_OFS:    rdata_r <= {31'h0, crc_en_r};
        STATUS_OFS:     rdata_r <= {frames_r, 14'h0, hi_pend_r, state_r};
        LAST_CRC_OFS:   rdata_r <= last_crc_r;
        LAST_STAMP_OFS: rdata_r <= last_stamp_r;
        default:        rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  // per-image feature snapshot and test pattern position
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frm_test_r  <= 1'b0;
      frm_stamp_r <= 1'b0;
      frm_crc_r   <= 1'b0;
      pattern_r   <= 12'h000;
    end else if (fire) begin
      frm_test_r  <= f_test;
      frm_stamp_r <= f_stamp;
      frm_crc_r   <= f_crc;
      pattern_r   <= pat_cur + 12'h001;
    end
  end

  // exposure time capture; a stamp belongs to the next image begun
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stamp_cap_r <= 32'h00000000;
      frm_time_r  <= 32'h00000000;
    end else begin
      if (exposure_start) begin
        stamp_cap_r <= cycle_time;
      end
      if (fire && in_first) begin
        frm_time_r <= exposure_start ? cycle_time : stamp_cap_r;
      end
    end
  end

  // checksum over every pixel byte handed to the link
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      crc_r <= CRC_INIT;
    end else if (fire) begin
      crc_r <= crc_byte(in_first ? CRC_INIT : crc_r, lo_byte);
    end else if (hi_load) begin
      crc_r <= crc_byte(crc_r, hi_byte_r);
    end
  end

  // pending high byte of a 16-bit component
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hi_pend_r <= 1'b0;
      hi_byte_r <= 8'h00;
      hi_last_r <= 1'b0;
    end else if (fire && wide_r) begin
      hi_pend_r <= 1'b1;
      hi_byte_r <= {4'h0, level[11:8]};
      hi_last_r <= in_last;
    end else if (hi_load) begin
      hi_pend_r <= 1'b0;
    end
  end

  // phase: pixel bytes, then trailer records when any are due
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= S_PIX;
      trl_idx_r <= 6'h00;
      rec_r     <= 1'b0;
    end else begin
      unique case (state_r)
        S_PIX: begin
          trl_idx_r <= 6'h00;
          rec_r     <= !f_stamp;
          if (fire && in_last && !wide_r && f_app) begin
            state_r <= S_TRL;
          end else if (hi_load && hi_last_r
                       && (frm_stamp_r || frm_crc_r)) begin
            state_r <= S_TRL;
            rec_r   <= !frm_stamp_r;
          end
        end
        S_TRL: begin
          if (trl_load) begin
            if (trl_done) begin
              state_r <= S_PIX;
            end else if (trl_idx_r == REC_LAST) begin
              trl_idx_r <= 6'h00;
              rec_r     <= 1'b1;
            end else begin
              trl_idx_r <= trl_idx_r + 6'h01;
            end
          end
        end
      endcase
    end
  end

  // output byte slot; the block loads it only when it is empty or its byte is taken at the same edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_r <= 1'b0;
      out_data_r  <= 8'h00;
      out_last_r  <= 1'b0;
    end else if (fire) begin
      out_valid_r <= 1'b1;
      out_data_r  <= lo_byte;
      out_last_r  <= in_last && !wide_r && !f_app;
    end else if (hi_load) begin
      out_valid_r <= 1'b1;
      out_data_r  <= hi_byte_r;
      out_last_r  <= hi_last_r && !(frm_stamp_r || frm_crc_r);
    end else if (trl_load) begin
      out_valid_r <= 1'b1;
      out_data_r  <= trl_byte;
      out_last_r  <= trl_done;
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
      out_last_r  <= 1'b0;
    end
  end

  // ready is registered, so it is only raised for a slot that is free
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_ready_r <= 1'b0;
    end else begin
      in_ready_r <= (state_r == S_PIX) && !fire && !hi_pend_r && slot_free;
    end
  end
  // results of the last finished image, and image count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_crc_r   <= 32'h00000000;
      last_stamp_r <= 32'h00000000;
      frames_r     <= 16'h0000;
    end else if (out_valid_r && out_ready && out_last_r) begin
      last_crc_r   <= ~crc_r;
      last_stamp_r <= frm_time_r;
      frames_r     <= frames_r + 16'h0001;
    end
  end

  assign in_ready  = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;
  assign out_last  = out_last_r;
  assign reg_rdata = rdata_r;
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  mono_byte_map_a: assert property (
    fire && !wide_r && !in_chroma && !f_test |=>
      out_data_r == $past(in_level[11:4]))
    else $error("mono byte differs from signal level");
  chroma_offset_a: assert property (
    fire && !wide_r && in_chroma && !f_test |=>
      out_data_r == ($past(in_level[11:4]) ^ CHROMA_ZERO))
    else $error("chroma byte not offset binary");
  wide_low_first_a: assert property (
    fire && wide_r && !f_test |=> out_data_r == $past(in_level[7:0])
      && hi_pend_r && hi_byte_r == {4'h0, $past(in_level[11:8])})
    else $error("16-bit word not sent low byte first");
  wide_top_zero_a: assert property (
    hi_load |=> out_data_r == {4'h0, $past(hi_byte_r[3:0])})
    else $error("top bits of 16-bit word not zero");
  test_ramp_a: assert property (
    fire && in_first && test_en_r && !test_white_r && !wide_r
      && !in_chroma |=> out_data_r == 8'h00)
    else $error("test image does not start its ramp");
  trailer_gate_a: assert property (
    fire && in_first && !live_app |=> !frm_stamp_r && !frm_crc_r)
    else $error("records armed without extended stream in format 7");
  guid_lead_a: assert property (
    trl_load && trl_idx_r == 6'h00 && !rec_r |=>
      out_data_r == GUID_STAMP[7:0])
    else $error("stamp record does not open with its identifier");
  stamp_payload_a: assert property (
    trl_load && trl_idx_r == GUID_BYTES && !rec_r |=>
      out_data_r == $past(frm_time_r[7:0]))
    else $error("stamp payload wrong");
  crc_payload_a: assert property (
    trl_load && trl_idx_r == GUID_BYTES && rec_r |=>
      out_data_r == ~$past(crc_r[7:0]))
    else $error("checksum payload wrong");
  csr_enable_a: assert property (
    reg_wr && reg_addr == CRC_CSR_OFS |=>
      crc_en_r == $past(reg_wdata[ENABLE_BIT]))
    else $error("checksum enable not taken from its register");
  slot_free_a: assert property (in_ready_r |-> !out_valid_r)
    else $error("ready raised over an occupied slot");

  both_records_c: cover property (trl_load && trl_done && rec_r
                                  && frm_stamp_r);
  wide_frame_c:   cover property (hi_load && hi_last_r);
  test_frame_c:   cover property (fire && in_last && frm_test_r);
  plain_frame_c:  cover property (fire && in_last && !f_app && !wide_r);
endmodule : pixel_component_formatter

// ===== dv/host_sink.sv
// host_sink: byte sink standing in for the host end of the link.
// assumes the formatter's byte stream runs on the same clock.
`timescale 1ns/1ns
module host_sink (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       stall_en,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready,
  output logic            got,
  output logic [7:0]      got_data,
  output logic            got_last
);
  logic [7:0] lfsr_r;

  // pseudo random back pressure, so a slow host stalls about half the time
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lfsr_r <= 8'h5a;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
  end

  // ready only after reset; a byte is taken at each edge with both high
  assign out_ready = reset_n && (!stall_en || lfsr_r[0]);
  assign got       = out_valid && out_ready;
  assign got_data  = out_data;
  assign got_last  = out_last;
endmodule : host_sink

// ===== dv/pixel_component_formatter_test.sv
// pixel_component_formatter_test: self-checking bench for the formatter.
// assumes formatter_pkg and host_sink are compiled ahead of this file.
`timescale 1ns/1ns
module pixel_component_formatter_test;
  import formatter_pkg::*;
  logic        clock          = 1'b0;
  logic        reset_n        = 1'b0;
  logic        in_valid       = 1'b0;
  logic [11:0] in_level       = 12'h000;
  logic        in_chroma      = 1'b0;
  logic        in_first       = 1'b0;
  logic        in_last        = 1'b0;
  logic        exposure_start = 1'b0;
  logic [31:0] cycle_time     = 32'h0;
  logic [7:0]  reg_addr       = 8'h00;
  logic [31:0] reg_wdata      = 32'h0;
  logic        reg_wr         = 1'b0;
  logic        reg_rd         = 1'b0;
  logic        stall_en       = 1'b0;
  logic        in_ready, out_valid, out_last, out_ready, got, got_last;
  logic [7:0]  out_data, got_data;
  logic [31:0] reg_rdata, crc;
  logic [31:0] seed           = 32'h6b65;
  logic [7:0]  exp_q[$], got_q[$];
  logic [11:0] c_lv [4]       = '{12'hfff, 12'h000, 12'h800, 12'h7f0};
  logic        c_ch [4]       = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [6:0]  c_cfg [4]      = '{7'h3c, 7'h7f, 7'h2d, 7'h1d};
  int          err_total      = 0;
  int          checks         = 0;

  always #5 clock = ~clock;

  pixel_component_formatter i_dut (
    .clock(clock), .reset_n(reset_n), .in_valid(in_valid),
    .in_level(in_level), .in_chroma(in_chroma), .in_first(in_first),
    .in_last(in_last), .in_ready(in_ready),
    .exposure_start(exposure_start), .cycle_time(cycle_time),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  host_sink i_host (
    .clock(clock), .reset_n(reset_n), .stall_en(stall_en),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready), .got(got), .got_data(got_data),
    .got_last(got_last)
  );

  // xorshift source, fixed seed keeps runs repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // reflected crc, one byte at a time
  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] b);
    c ^= {24'h0, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

  // pixel bytes also feed the expected checksum
  function automatic void push(logic [7:0] b, logic pix);
    exp_q.push_back(b);
    if (pix) begin
      crc = crc_byte(crc, b);
    end
  endfunction : push

  // a record is the identifier then the payload, low byte first
  function automatic void push_rec(logic [127:0] id, logic [31:0] pay);
    for (int i = 0; i < 16; i++) begin
      push(id[8*i +: 8], 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      push(pay[8*i +: 8], 1'b0);
    end
  endfunction : push_rec

  task automatic check(logic [31:0] got_v, logic [31:0] exp_v, string what);
    checks++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got_v, exp_v);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic reg_write(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task automatic reg_read(logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // offer one component and hold it until the edge that takes it
  task automatic put(logic [11:0] lv, logic ch, logic f, logic l);
    int n = 0;
    in_valid  <= 1'b1;
    in_level  <= lv;
    in_chroma <= ch;
    in_first  <= f;
    in_last   <= l;
    do begin
      @(posedge clock);
      n++;
    end while (!in_ready && n < 200);
    if (n >= 200) begin
      check(0, 1, "input never taken");
      end_sim();
    end
  endtask : put

  // cfg: 0 wide, 1 test, 2 stamp, 3 crc, 4 ext, 5 format 7, 6 stall
  task automatic run_image(logic [6:0] c);
    logic [31:0] ts, r;
    logic [11:0] lv, v;
    logic        ch, wt;
    int          n, t, npix;
    ts = rnd();
    wt = ts[0];
    stall_en <= c[6];
    reg_write(FMT_CTRL_OFS,
              {25'h0, (c[5] ? VFMT_SCALABLE : VFMT_RESET), 3'h0, c[0]});
    reg_write(EXT_CSR_OFS, {31'h0, c[4]});
    reg_write(TEST_CSR_OFS, {30'h0, wt, c[1]});
    reg_write(STAMP_CSR_OFS, {31'h0, c[2]});
    reg_write(CRC_CSR_OFS, {31'h0, c[3]});
    n = 4 + int'(rnd() % 32'd6);
    t = 0;
    exp_q.delete();
    got_q.delete();
    crc = CRC_INIT;
    @(posedge clock);
    cycle_time     <= ts;
    exposure_start <= 1'b1;
    @(posedge clock);
    exposure_start <= 1'b0;
    cycle_time     <= rnd();
    fork
      begin
        for (int k = 0; k < n; k++) begin
          r = rnd();
          lv = (k < 4) ? c_lv[k] : r[11:0];
          ch = !c[0] && ((k < 4) ? c_ch[k] : r[12]);
          v = c[1] ? (wt ? WHITE_LEVEL : 12'(k)) : lv;
          if (c[0]) begin
            push(v[7:0], 1'b1);
            push({4'h0, v[11:8]}, 1'b1);
          end else begin
            push(ch ? {~v[11], v[10:4]} : v[11:4], 1'b1);
          end
          put(lv, ch, k == 0, k == n - 1);
        end
        in_valid <= 1'b0;
      end
      begin
        do begin
          @(posedge clock);
          t++;
          if (got) begin
            got_q.push_back(got_data);
          end
        end while (!(got && got_last) && t < 2000);
        if (t >= 2000) begin
          check(0, 1, "image never ended");
          end_sim();
        end
      end
    join
    npix = exp_q.size();
    if (c[4] && c[5] && c[2]) push_rec(GUID_STAMP, ts);
    if (c[4] && c[5] && c[3]) push_rec(GUID_CRC, ~crc);
    check(got_q.size(), exp_q.size(), "byte count");
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      if (i < npix) begin
        check(got_q[i], exp_q[i], "pixel byte");
      end else begin
        check(got_q[i], exp_q[i], "trailer byte");
      end
    end
    // results of the finished image stay readable until the next one
    reg_read(LAST_CRC_OFS, r);
    check(r, ~crc, "last checksum");
    reg_read(LAST_STAMP_OFS, r);
    check(r, ts, "last stamp");
  endtask : run_image

  // reset, register checks, corner images, then random images
  initial begin
    logic [31:0] d, m;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    for (logic [7:0] a = 8'h00; a <= 8'h20; a += 8'h04) begin
      reg_read(a, d);
      check(d, 32'h0, "reset value");
    end
    for (logic [7:0] a = EXT_CSR_OFS; a <= CRC_CSR_OFS; a += 8'h04) begin
      m = (a == TEST_CSR_OFS) ? 32'h3 : 32'h1;
      reg_write(a, 32'h3);
      reg_read(a, d);
      check(d & m, m, "feature csr");
    end
    reg_write(8'h24, 32'hffffffff);
    reg_read(8'h24, d);
    check(d, 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      run_image(c_cfg[i]);
    end
    repeat (12) begin
      d = rnd();
      run_image(d[6:0]);
    end
    end_sim();
  end
endmodule : pixel_component_formatter_test
